// ### core/flash_cmd_decoder.sv
/*
 * Command front end of a serial flash: frames on chip select, decodes the
 * opcode, gathers address and dummy bytes, forwards written data bytes
 * through a two-entry buffer and shifts read bytes out on falling edges.
 * Assumes CS_N, SCK and IO_IN are synchronous to CLOCK and that SCK runs
 * well below half the CLOCK rate so every serial edge is seen.
 */
// Functional notes
// - frame starts at chip select low; first 8 bits form the opcode
// - all bytes move most significant bit first, both directions
// - chip select high ends the current command frame
// - unsupported opcode starts no operation
// - after unsupported opcode all input ignored until chip select cycles
// - chip select high before opcode and address complete does nothing
// - addressed commands take three address bytes, high bit first
// - upper three address bits are dropped; 21 bits are kept
// - array reads: 1Bh two dummies, 0Bh one, 03h none, then data
// - dual and quad output reads take address, one dummy, then data
// - block erases take three address bytes, nothing more
// - chip erase is recognised under both opcodes, opcode alone
// - page programs take address, no dummy, one to 256 data bytes
// - suspend and resume are opcode alone
// - write enable and write disable are opcode alone
// - protect, unprotect take address; protection read returns data
// - lockdown and freeze take address plus one byte; read returns data
// - security area program takes address and data; read adds two dummies
// - status read returns data; each status write takes one byte
// - configuration read returns data; write takes one byte
// - soft reset takes one byte; power down and resume opcode alone
// - identity read returns one to five bytes, no address
// - sample on rising serial clock, drive on falling, both idle levels
// - quad commands and quad pins only when quad_io_enable is set
`timescale 1ns/100ps
`default_nettype none

module flash_cmd_decoder
	import flash_cmd_pkg::*;
(
	// clock and reset
	input  wire logic       CLOCK,
	input  wire logic       RST,
	// serial pins
	input  wire logic       CS_N,
	input  wire logic       SCK,
	input  wire logic [3:0] IO_IN,
	output logic      [3:0] IO_OUT,
	output logic      [3:0] IO_OE,
	// configuration
	input  wire logic       QUAD_IO_ENABLE,
	// decoded command
	output logic            CMD_VALID,
	output var cmd_t        CMD,
	output logic            DONE,
	output logic            DONE_OK,
	// received data stream
	output logic            RX_VALID,
	output var rx_word_t    RX_DATA,
	input  wire logic       RX_READY,
	output logic            RX_OVERRUN,
	// read data source
	input  wire logic [7:0] TX_DATA,
	output logic            TX_TAKE
);

	logic       sck_q;
	logic       cs_n_q;
	state_t     state_q;
	state_t     state_d;
	state_t     cur_st;
	logic [2:0] bit_q;
	logic [2:0] bit_d;
	logic [7:0] sr_q;
	logic [7:0] sr_d;
	logic [8:0] cnt_q;
	logic [8:0] cnt_d;
	cmd_info_t  info_q;
	cmd_info_t  info_d;
	logic [7:0] op_q;
	logic [7:0] op_d;
	logic [23:0] addr_q;
	logic [23:0] addr_d;
	logic       hdr_q;
	logic       hdr_now;
	logic       push;
	logic [3:0] rise_cnt_q;
	logic [7:0] tx_q;
	logic [2:0] tx_bit_q;
	logic [8:0] tx_cnt_q;

	// serial edges, seen only inside a frame
	wire logic rise  = !CS_N && SCK && !sck_q;
	wire logic fall  = !CS_N && !SCK && sck_q;
	wire logic cs_up = CS_N && !cs_n_q;

	// idle behaves as the opcode phase so a first edge in the same cycle
	// as chip select falling is not lost
	assign cur_st = (state_q == ST_IDLE) ? ST_OPC : state_q;

	wire logic [2:0] lanes_in = (cur_st == ST_DATA) ? info_q.lanes : LANE_1;
	wire logic [3:0] bit_nx   = {1'b0, bit_q} + {1'b0, lanes_in};
	wire logic byte_full      = rise && (bit_nx == BYTE_BITS);
	wire logic [7:0] sr_nx    = shift_in(sr_q, IO_IN, lanes_in);
	wire cmd_info_t dec       = decode(sr_nx);
	wire logic supported      = dec.ok && (!dec.quad || QUAD_IO_ENABLE);
	wire logic [23:0] addr_cat = {addr_q[15:0], sr_nx};
	wire logic [8:0] cnt_inc  = cnt_q + 9'h001;
	wire logic last_addr  = cnt_q[1:0] == 2'(info_q.addr_n - 2'h1);
	wire logic last_dummy = cnt_q[1:0] == 2'(info_q.dummy_n - 2'h1);
	wire logic data_cap   = (info_q.data_max != DATA_OPEN)
		&& (cnt_inc == info_q.data_max);

	// header seen in the opcode byte itself carries the fresh decode
	wire logic [7:0] hdr_op   = (cur_st == ST_OPC) ? sr_nx : op_q;
	wire cmd_info_t  hdr_info = (cur_st == ST_OPC) ? dec : info_q;
	wire logic [23:0] hdr_addr = (cur_st == ST_ADDR) ? addr_cat : addr_q;
	wire cmd_t cmd_d = '{opcode: hdr_op,
		addr: hdr_addr[ADDR_USED-1:0], info: hdr_info};

	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		sr_d    = sr_q;
		cnt_d   = cnt_q;
		info_d  = info_q;
		op_d    = op_q;
		addr_d  = addr_q;
		hdr_now = 1'b0;
		push    = 1'b0;
		if (CS_N) begin
			state_d = ST_IDLE;
			bit_d   = 3'h0;
			cnt_d   = 9'h000;
			addr_d  = 24'h000000;
		end else begin
			state_d = cur_st;
			if (rise && cur_st != ST_SKIP) begin
				bit_d = bit_nx[2:0];
				sr_d  = sr_nx;
			end
			if (byte_full) begin
				case (cur_st)
					ST_OPC: begin
						if (!supported) begin
							state_d = ST_SKIP;
						end else begin
							info_d = dec;
							op_d   = sr_nx;
							cnt_d  = 9'h000;
							if (dec.addr_n != ADDR_NONE) begin
								state_d = ST_ADDR;
							end else begin
								hdr_now = 1'b1;
							end
						end
					end
					ST_ADDR: begin
						addr_d = addr_cat;
						cnt_d  = cnt_inc;
						if (last_addr) begin
							cnt_d = 9'h000;
							if (info_q.dummy_n != DUMMY_NONE) begin
								state_d = ST_DUMMY;
							end else begin
								hdr_now = 1'b1;
							end
						end
					end
					ST_DUMMY: begin
						cnt_d = cnt_inc;
						if (last_dummy) begin
							hdr_now = 1'b1;
						end
					end
					ST_DATA: begin
						// commands without data forward no stray bytes
						if (!info_q.rd && info_q.data_req) begin
							push  = 1'b1;
							cnt_d = cnt_inc;
							if (data_cap) begin
								state_d = ST_SKIP;
							end
						end
					end
					default: ;
				endcase
			end
			if (hdr_now) begin
				state_d = ST_DATA;
				cnt_d   = 9'h000;
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			sck_q   <= 1'b0;
			cs_n_q  <= 1'b1;
			state_q <= ST_IDLE;
			bit_q   <= 3'h0;
			sr_q    <= 8'h00;
			cnt_q   <= 9'h000;
			info_q  <= '0;
			op_q    <= 8'h00;
			addr_q  <= 24'h000000;
		end else begin
			sck_q   <= SCK;
			cs_n_q  <= CS_N;
			state_q <= state_d;
			bit_q   <= bit_d;
			sr_q    <= sr_d;
			cnt_q   <= cnt_d;
			info_q  <= info_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
		end
	end

	// command report; a frame that never completed its header reports nothing
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CMD_VALID <= 1'b0;
			CMD       <= '0;
			hdr_q     <= 1'b0;
			DONE      <= 1'b0;
			DONE_OK   <= 1'b0;
		end else begin
			CMD_VALID <= hdr_now;
			if (hdr_now) begin
				CMD <= cmd_d;
			end
			hdr_q   <= !CS_N && (hdr_q || hdr_now);
			DONE    <= cs_up && hdr_q;
			DONE_OK <= cs_up && hdr_q && (!info_q.data_req
				|| (info_q.rd ? tx_cnt_q != 9'h000 : cnt_q != 9'h000));
		end
	end

	// read data: loaded at a byte boundary on the falling edge
	wire logic tx_run  = fall && state_q == ST_DATA && info_q.rd;
	wire logic tx_load = tx_run && tx_bit_q == 3'h0;
	wire logic tx_stop = (info_q.data_max != DATA_OPEN)
		&& (tx_cnt_q == info_q.data_max);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tx_q     <= 8'h00;
			tx_bit_q <= 3'h0;
			tx_cnt_q <= 9'h000;
			IO_OUT   <= 4'h0;
			IO_OE    <= 4'h0;
			TX_TAKE  <= 1'b0;
		end else if (CS_N) begin
			tx_bit_q <= 3'h0;
			tx_cnt_q <= 9'h000;
			IO_OE    <= 4'h0;
			TX_TAKE  <= 1'b0;
		end else begin
			TX_TAKE <= tx_load && !tx_stop;
			if (tx_load && tx_stop) begin
				IO_OE <= 4'h0;
			end else if (tx_load) begin
				IO_OUT   <= place(TX_DATA, info_q.lanes);
				tx_q     <= TX_DATA << info_q.lanes;
				IO_OE    <= lane_mask(info_q.lanes);
				tx_cnt_q <= tx_cnt_q + 9'h001;
				tx_bit_q <= info_q.lanes;
			end else if (tx_run) begin
				IO_OUT   <= place(tx_q, info_q.lanes);
				tx_q     <= tx_q << info_q.lanes;
				tx_bit_q <= tx_bit_q + info_q.lanes;
			end
		end
	end

	// two-entry buffer: the serial host cannot be stalled, so a full buffer
	// drops the byte and flags it rather than corrupting older words
	rx_word_t   ent1_q;
	logic       v1_q;
	wire rx_word_t word_in = '{data: sr_nx, first: cnt_q == 9'h000};
	wire logic pop       = RX_VALID && RX_READY;
	wire logic buf_ready = !v1_q || pop;
	wire logic take_in   = push && buf_ready;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RX_VALID   <= 1'b0;
			RX_DATA    <= '0;
			ent1_q     <= '0;
			v1_q       <= 1'b0;
			RX_OVERRUN <= 1'b0;
		end else begin
			RX_OVERRUN <= push && !buf_ready;
			if (pop && v1_q) begin
				RX_DATA <= ent1_q;
				v1_q    <= take_in;
				if (take_in) begin
					ent1_q <= word_in;
				end
			end else if (pop || !RX_VALID) begin
				RX_VALID <= take_in;
				if (take_in) begin
					RX_DATA <= word_in;
				end
			end else if (take_in) begin
				ent1_q <= word_in;
				v1_q   <= 1'b1;
			end
		end
	end

	// rising edges seen in this frame, for checking the decode point
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rise_cnt_q <= 4'h0;
		end else if (CS_N) begin
			rise_cnt_q <= 4'h0;
		end else if (rise && rise_cnt_q != 4'hF) begin
			rise_cnt_q <= rise_cnt_q + 4'h1;
		end
	end

	opc_edge_a: assert property (@(posedge CLOCK) disable iff (RST)
		(byte_full && cur_st == ST_OPC) |-> rise_cnt_q == 4'h7)
		else $error("opcode decoded off the eighth rising edge");

	bad_opc_a: assert property (@(posedge CLOCK) disable iff (RST)
		(byte_full && cur_st == ST_OPC && !supported)
		|=> !CMD_VALID && (state_q == ST_SKIP || state_q == ST_IDLE))
		else $error("unsupported opcode started a command");

	skip_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
		(state_q == ST_SKIP && !CS_N) |-> !push ##1 !CMD_VALID
		&& (state_q == ST_SKIP || state_q == ST_IDLE))
		else $error("input acted on after an ignored opcode");

	frame_end_a: assert property (@(posedge CLOCK) disable iff (RST)
		cs_up |=> state_q == ST_IDLE && IO_OE == 4'h0 && !CMD_VALID)
		else $error("frame not closed by chip select");

	early_end_a: assert property (@(posedge CLOCK) disable iff (RST)
		(cs_up && !hdr_q) |=> !DONE ##1 !DONE)
		else $error("incomplete frame reported as done");

	quad_gate_a: assert property (@(posedge CLOCK) disable iff (RST)
		(CMD_VALID && CMD.info.quad) |-> $past(QUAD_IO_ENABLE))
		else $error("quad command taken with quad lines disabled");

	data_cap_a: assert property (@(posedge CLOCK) disable iff (RST)
		(push && info_q.data_max != DATA_OPEN) |-> cnt_q < info_q.data_max)
		else $error("data byte beyond command limit forwarded");

	rx_hold_a: assert property (@(posedge CLOCK) disable iff (RST)
		(RX_VALID && !RX_READY) |=> RX_VALID && $stable(RX_DATA))
		else $error("buffered byte changed before it was taken");

endmodule : flash_cmd_decoder

`default_nettype wire

// ### core/flash_cmd_pkg.sv
/*
 * Shared definitions for the serial flash command decoder: opcodes, the
 * per-command byte layout, carrier structs, frame states and the helpers
 * that decode opcodes and move bits between bytes and data lines.
 * Assumes one command table per device and at most four data lines.
 */
package flash_cmd_pkg;

	// opcodes
	localparam logic [7:0] OP_READ_TOP   = 8'h1B;
	localparam logic [7:0] OP_READ_FAST  = 8'h0B;
	localparam logic [7:0] OP_READ_SLOW  = 8'h03;
	localparam logic [7:0] OP_READ_DUAL  = 8'h3B;
	localparam logic [7:0] OP_READ_QUAD  = 8'h6B;
	localparam logic [7:0] OP_ERASE_4K   = 8'h20;
	localparam logic [7:0] OP_ERASE_32K  = 8'h52;
	localparam logic [7:0] OP_ERASE_64K  = 8'hD8;
	localparam logic [7:0] OP_ERASE_ALLA = 8'h60;
	localparam logic [7:0] OP_ERASE_ALLB = 8'hC7;
	localparam logic [7:0] OP_PROG       = 8'h02;
	localparam logic [7:0] OP_PROG_DUAL  = 8'hA2;
	localparam logic [7:0] OP_PROG_QUAD  = 8'h32;
	localparam logic [7:0] OP_SUSPEND    = 8'hB0;
	localparam logic [7:0] OP_RESUME     = 8'hD0;
	localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_PROTECT    = 8'h36;
	localparam logic [7:0] OP_UNPROTECT  = 8'h39;
	localparam logic [7:0] OP_RD_PROTECT = 8'h3C;
	localparam logic [7:0] OP_LOCK       = 8'h33;
	localparam logic [7:0] OP_LOCK_FRZ   = 8'h34;
	localparam logic [7:0] OP_RD_LOCK    = 8'h35;
	localparam logic [7:0] OP_OTP_PROG   = 8'h9B;
	localparam logic [7:0] OP_OTP_READ   = 8'h77;
	localparam logic [7:0] OP_RD_STATUS  = 8'h05;
	localparam logic [7:0] OP_WR_STAT1   = 8'h01;
	localparam logic [7:0] OP_WR_STAT2   = 8'h31;
	localparam logic [7:0] OP_RD_CONFIG  = 8'h3F;
	localparam logic [7:0] OP_WR_CONFIG  = 8'h3E;
	localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
	localparam logic [7:0] OP_READ_ID    = 8'h9F;
	localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_POWER_UP   = 8'hAB;

	// byte counts and widths
	localparam logic [1:0] ADDR_NONE     = 2'h0;
	localparam logic [1:0] ADDR_FULL     = 2'h3;
	localparam logic [1:0] DUMMY_NONE    = 2'h0;
	localparam logic [1:0] DUMMY_ONE     = 2'h1;
	localparam logic [1:0] DUMMY_TWO     = 2'h2;
	localparam logic [8:0] DATA_OPEN     = 9'h000;
	localparam logic [8:0] DATA_ONE      = 9'h001;
	localparam logic [8:0] DATA_PAGE     = 9'h100;
	localparam logic [8:0] DATA_ID       = 9'h005;
	localparam logic [2:0] LANE_1        = 3'h1;
	localparam logic [2:0] LANE_2        = 3'h2;
	localparam logic [2:0] LANE_4        = 3'h4;
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	localparam int         ADDR_USED     = 21;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_OPC   = 6'h02,
		ST_ADDR  = 6'h04,
		ST_DUMMY = 6'h08,
		ST_DATA  = 6'h10,
		ST_SKIP  = 6'h20
	} state_t;

	// data_max of zero means no upper limit
	typedef struct packed {
		logic       ok;
		logic [1:0] addr_n;
		logic [1:0] dummy_n;
		logic [8:0] data_max;
		logic       data_req;
		logic       rd;
		logic [2:0] lanes;
		logic       quad;
	} cmd_info_t;

	typedef struct packed {
		logic [7:0]          opcode;
		logic [ADDR_USED-1:0] addr;
		cmd_info_t           info;
	} cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       first;
	} rx_word_t;

	function automatic cmd_info_t mk(input logic [1:0] a, input logic [1:0] d,
			input logic [8:0] m, input logic q, input logic r,
			input logic [2:0] l, input logic qd);
		mk = '{ok: 1'b1, addr_n: a, dummy_n: d, data_max: m, data_req: q,
			rd: r, lanes: l, quad: qd};
	endfunction : mk

	function automatic cmd_info_t decode(input logic [7:0] op);
		case (op)
			OP_READ_TOP:   decode = mk(ADDR_FULL, DUMMY_TWO, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_READ_FAST:  decode = mk(ADDR_FULL, DUMMY_ONE, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_READ_SLOW:  decode = mk(ADDR_FULL, DUMMY_NONE, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_READ_DUAL:  decode = mk(ADDR_FULL, DUMMY_ONE, DATA_OPEN, 1'b1, 1'b1, LANE_2, 1'b0);
			OP_READ_QUAD:  decode = mk(ADDR_FULL, DUMMY_ONE, DATA_OPEN, 1'b1, 1'b1, LANE_4, 1'b1);
			OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROTECT, OP_UNPROTECT:
				decode = mk(ADDR_FULL, DUMMY_NONE, DATA_ONE, 1'b0, 1'b0, LANE_1, 1'b0);
			OP_ERASE_ALLA, OP_ERASE_ALLB, OP_SUSPEND, OP_RESUME, OP_WR_ENABLE,
			OP_WR_DISABLE, OP_POWER_DOWN, OP_POWER_UP:
				decode = mk(ADDR_NONE, DUMMY_NONE, DATA_ONE, 1'b0, 1'b0, LANE_1, 1'b0);
			OP_PROG:       decode = mk(ADDR_FULL, DUMMY_NONE, DATA_PAGE, 1'b1, 1'b0, LANE_1, 1'b0);
			OP_PROG_DUAL:  decode = mk(ADDR_FULL, DUMMY_NONE, DATA_PAGE, 1'b1, 1'b0, LANE_2, 1'b0);
			OP_PROG_QUAD:  decode = mk(ADDR_FULL, DUMMY_NONE, DATA_PAGE, 1'b1, 1'b0, LANE_4, 1'b1);
			OP_RD_PROTECT, OP_RD_LOCK:
				decode = mk(ADDR_FULL, DUMMY_NONE, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_LOCK, OP_LOCK_FRZ:
				decode = mk(ADDR_FULL, DUMMY_NONE, DATA_ONE, 1'b1, 1'b0, LANE_1, 1'b0);
			OP_OTP_PROG:   decode = mk(ADDR_FULL, DUMMY_NONE, DATA_OPEN, 1'b1, 1'b0, LANE_1, 1'b0);
			OP_OTP_READ:   decode = mk(ADDR_FULL, DUMMY_TWO, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_RD_STATUS, OP_RD_CONFIG:
				decode = mk(ADDR_NONE, DUMMY_NONE, DATA_OPEN, 1'b1, 1'b1, LANE_1, 1'b0);
			OP_WR_STAT1, OP_WR_STAT2, OP_WR_CONFIG, OP_SOFT_RESET:
				decode = mk(ADDR_NONE, DUMMY_NONE, DATA_ONE, 1'b1, 1'b0, LANE_1, 1'b0);
			OP_READ_ID:    decode = mk(ADDR_NONE, DUMMY_NONE, DATA_ID, 1'b1, 1'b1, LANE_1, 1'b0);
			default:       decode = '0;
		endcase
	endfunction : decode

	// msb first: the newest bits enter at the bottom
	function automatic logic [7:0] shift_in(input logic [7:0] sr,
			input logic [3:0] io, input logic [2:0] lanes);
		case (lanes)
			LANE_2:  shift_in = {sr[5:0], io[1:0]};
			LANE_4:  shift_in = {sr[3:0], io[3:0]};
			default: shift_in = {sr[6:0], io[0]};
		endcase
	endfunction : shift_in

	// single line drives the second pin; wider modes put bit 7 on the top lane
	function automatic logic [3:0] place(input logic [7:0] b,
			input logic [2:0] lanes);
		case (lanes)
			LANE_2:  place = {2'h0, b[7:6]};
			LANE_4:  place = b[7:4];
			default: place = {2'h0, b[7], 1'b0};
		endcase
	endfunction : place

	function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
		case (lanes)
			LANE_2:  lane_mask = 4'h3;
			LANE_4:  lane_mask = 4'hF;
			default: lane_mask = 4'h2;
		endcase
	endfunction : lane_mask

endpackage : flash_cmd_pkg

// ### verification/spi_host_model.sv
/*
 * Behavioural serial host that frames commands on chip select, shifts bytes
 * out on up to four lines and samples read bytes from the device outputs.
 * Assumes a bench clock; every pin change lands 1 ns after its rising edge.
 */
`timescale 1ns/100ps
`default_nettype none

module spi_host_model (
	// bench clock
	input  wire logic       clk,
	// serial pins toward the device
	output logic            cs_n,
	output logic            sck,
	output logic      [3:0] io,
	// device data lines
	input  wire logic [3:0] io_out
);
	int   hp    = 2;
	logic mode3 = 1'b0;

	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		io   = 4'h5;
	end

	// at least two clocks per serial phase, or the device misses edges
	task automatic half();
		repeat (hp) @(posedge clk);
		#1;
	endtask : half

	task automatic start(input logic m3);
		mode3 = m3;
		sck   = m3;
		half();
		cs_n  = 1'b0;
		half();
	endtask : start

	// unused lanes toggle so a stale level never looks like data
	task automatic put(input logic [7:0] b, input int lanes);
		logic [7:0] s;
		s = b;
		repeat (8 / lanes) begin
			sck = 1'b0;
			io  = (lanes == 4) ? s[7:4] : (lanes == 2) ? {~io[3:2], s[7:6]} :
				{~io[3:1], s[7]};
			half();
			sck = 1'b1;
			half();
			s = s << lanes;
		end
	endtask : put

	task automatic get(input int lanes, output logic [7:0] b);
		b = 8'h00;
		repeat (8 / lanes) begin
			sck = 1'b0;
			half();
			b = (lanes == 4) ? {b[3:0], io_out} : (lanes == 2) ?
				{b[5:0], io_out[1:0]} : {b[6:0], io_out[1]};
			sck = 1'b1;
			half();
		end
	endtask : get

	task automatic stop();
		if (!mode3) begin
			sck = 1'b0;
			half();
		end
		cs_n = 1'b1;
		io   = ~io;
		half();
	endtask : stop
endmodule : spi_host_model

`default_nettype wire

// ### verification/tb_serial_flash_command_decoder.sv
/*
 * Self-checking bench for the flash command decoder: sweeps every opcode,
 * checks header decode, read lanes, write stream, limits and refusals.
 * Assumes the host model drives the serial pins and this bench the rest.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_serial_flash_command_decoder;
	import flash_cmd_pkg::*;

	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       quad_en = 1'b1;
	logic       rx_ready = 1'b0;
	logic       stall = 1'b0;
	logic       cmd_valid, done, done_ok, rx_valid, rx_overrun, tx_take;
	logic       dok;
	logic [3:0] io_out, io_oe;
	logic [7:0] tx_data;
	cmd_t       cmd;
	rx_word_t   rx_data;
	rx_word_t   rxq[$];
	wire logic  cs_n, sck;
	wire logic [3:0] host_io, io_bus;
	int         error_cnt = 0, checked = 0, seed = 32'h4aff;
	int         tx_idx = 0, cv_n = 0, dn_n = 0, ov_n = 0, tx_base = 0;

	always #2 clock = ~clock;
	assign io_bus = (io_oe & io_out) | (~io_oe & host_io);

	function automatic logic [7:0] seq(input int k);
		seq = 8'hC3 ^ (k[7:0] * 8'h1D);
	endfunction : seq

	// {ok, addr bytes, dummies, data, read, lanes, data limit (0 open)}
	function automatic logic [18:0] lay(input logic [7:0] op);
		case (op)
			8'h1B, 8'h77: lay = {1'b1, 2'h3, 2'h2, 2'h3, 3'h1, 9'h000};
			8'h0B: lay = {1'b1, 2'h3, 2'h1, 2'h3, 3'h1, 9'h000};
			8'h03, 8'h3C, 8'h35: lay = {1'b1, 2'h3, 2'h0, 2'h3, 3'h1, 9'h000};
			8'h3B: lay = {1'b1, 2'h3, 2'h1, 2'h3, 3'h2, 9'h000};
			8'h6B: lay = {1'b1, 2'h3, 2'h1, 2'h3, 3'h4, 9'h000};
			8'h20, 8'h52, 8'hD8, 8'h36, 8'h39:
				lay = {1'b1, 2'h3, 2'h0, 2'h0, 3'h1, 9'h000};
			8'h60, 8'hC7, 8'hB0, 8'hD0, 8'h06, 8'h04, 8'hB9, 8'hAB:
				lay = {1'b1, 2'h0, 2'h0, 2'h0, 3'h1, 9'h000};
			8'h02: lay = {1'b1, 2'h3, 2'h0, 2'h2, 3'h1, 9'h100};
			8'hA2: lay = {1'b1, 2'h3, 2'h0, 2'h2, 3'h2, 9'h100};
			8'h32: lay = {1'b1, 2'h3, 2'h0, 2'h2, 3'h4, 9'h100};
			8'h33, 8'h34: lay = {1'b1, 2'h3, 2'h0, 2'h2, 3'h1, 9'h001};
			8'h9B: lay = {1'b1, 2'h3, 2'h0, 2'h2, 3'h1, 9'h000};
			8'h05, 8'h3F: lay = {1'b1, 2'h0, 2'h0, 2'h3, 3'h1, 9'h000};
			8'h01, 8'h31, 8'h3E, 8'hF0:
				lay = {1'b1, 2'h0, 2'h0, 2'h2, 3'h1, 9'h001};
			8'h9F: lay = {1'b1, 2'h0, 2'h0, 2'h3, 3'h1, 9'h005};
			default: lay = 19'h00000;
		endcase
	endfunction : lay

	assign tx_data = seq(tx_idx - tx_base);

	always @(posedge clock) begin
		if (tx_take)
			tx_idx <= tx_idx + 1;
		if (cmd_valid)
			cv_n <= cv_n + 1;
		if (done) begin
			dn_n <= dn_n + 1;
			dok  <= done_ok;
		end
		if (rx_valid && rx_ready)
			rxq.push_back(rx_data);
		if (rx_overrun)
			ov_n <= ov_n + 1;
		rx_ready <= !stall && (($random(seed) & 1) != 0);
	end

	spi_host_model host (.clk(clock), .cs_n(cs_n), .sck(sck), .io(host_io),
		.io_out(io_out));

	flash_cmd_decoder DUT (.CLOCK(clock), .RST(rst), .CS_N(cs_n), .SCK(sck),
		.IO_IN(io_bus), .IO_OUT(io_out), .IO_OE(io_oe),
		.QUAD_IO_ENABLE(quad_en), .CMD_VALID(cmd_valid), .CMD(cmd),
		.DONE(done), .DONE_OK(done_ok), .RX_VALID(rx_valid),
		.RX_DATA(rx_data), .RX_READY(rx_ready), .RX_OVERRUN(rx_overrun),
		.TX_DATA(tx_data), .TX_TAKE(tx_take));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// one whole supported frame; n data bytes written or read
	task automatic run_cmd(input logic [7:0] op, input logic m3, input int n);
		logic [18:0] e;
		logic [23:0] a;
		logic [7:0]  b;
		int          c0, d0, nexp, ln;
		e  = lay(op);
		a  = 24'($random(seed));
		c0 = cv_n;
		d0 = dn_n;
		ln = int'(e[11:9]);
		rxq.delete();
		tx_base = tx_idx;
		host.hp = 2 + ($random(seed) & 1);
		host.start(m3);
		host.put(op, 1);
		if (e[17])
			for (int i = 2; i >= 0; i--)
				host.put(a[i*8 +: 8], 1);
		repeat (e[15:14]) host.put(8'($random(seed)), 1);
		if (e[13] && e[12]) begin
			for (int k = 0; k < n; k++) begin
				host.get(ln, b);
				if (op == 8'h9F && k >= 5)
					chk(io_oe, 4'h0);
				else begin
					chk(b, seq(k));
					chk(io_oe, ln == 4 ? 4'hF : ln == 2 ? 4'h3 : 4'h2);
				end
			end
		end else if (e[13])
			for (int k = 0; k < n; k++)
				host.put(seq(k + 9), ln);
		host.stop();
		repeat (12) @(posedge clock);
		#1;
		chk(cv_n - c0, 1);
		chk({cmd.opcode, 3'h0, cmd.addr},
			{op, 3'h0, e[17] ? a[20:0] : 21'h000000});
		chk({cmd.info.ok, cmd.info.addr_n, cmd.info.dummy_n, cmd.info.data_req,
			cmd.info.rd, cmd.info.lanes, cmd.info.data_req ? cmd.info.data_max :
			9'h000}, e);
		chk(dn_n - d0, 1);
		chk(dok, n > 0 || !e[13]);
		chk(cmd.info.quad, op inside {8'h6B, 8'h32});
		nexp = (e[13] && !e[12]) ? n : 0;
		if (e[8:0] != 9'h000 && nexp > int'(e[8:0]))
			nexp = int'(e[8:0]);
		chk(rxq.size(), nexp);
		for (int k = 0; k < nexp; k++)
			chk({rxq[k].data, rxq[k].first}, {seq(k + 9), k == 0});
	endtask : run_cmd

	// refused or cut frame: nothing may start
	task automatic run_bad(input logic [7:0] op, input int nb);
		int c0, d0;
		c0 = cv_n;
		d0 = dn_n;
		rxq.delete();
		host.start(1'b0);
		host.put(op, 1);
		host.put(8'h06, 1);
		repeat (nb - 1) host.put(8'($random(seed)), 1);
		chk(io_oe, 4'h0);
		host.stop();
		repeat (4) @(posedge clock);
		#1;
		chk(cv_n - c0, 0);
		chk(dn_n - d0, 0);
		chk(rxq.size(), 0);
	endtask : run_bad

	initial begin
		int o0;
		repeat (16) @(posedge clock);
		#1;
		rst = 1'b0;
		for (int op = 0; op < 256; op++)
			if (lay(8'(op)) != 19'h00000)
				run_cmd(8'(op), 1'b0, op == 8'h9F ? 6 : 2);
			else
				run_bad(8'(op), 2);
		quad_en = 1'b0;
		run_bad(OP_READ_QUAD, 2);
		run_bad(OP_PROG_QUAD, 2);
		quad_en = 1'b1;
		run_bad(OP_PROG, 2);
		run_cmd(OP_PROG_QUAD, 1'b0, 257);
		run_cmd(OP_READ_FAST, 1'b1, 3);
		run_cmd(OP_PROG_DUAL, 1'b1, 2);
		run_cmd(OP_WR_STAT1, 1'b1, 0);
		// receiver stalls: two words held, third dropped
		stall = 1'b1;
		o0 = ov_n;
		rxq.delete();
		host.start(1'b0);
		host.put(OP_OTP_PROG, 1);
		for (int k = 0; k < 6; k++)
			host.put(seq(k + 40), 1);
		host.stop();
		chk(ov_n - o0, 1);
		stall = 1'b0;
		repeat (12) @(posedge clock);
		#1;
		chk(rxq.size(), 2);
		chk({rxq[0].data, rxq[0].first, rxq[1].data, rxq[1].first},
			{seq(43), 1'b1, seq(44), 1'b0});
		conclude();
	end

	initial begin
		repeat (90000) @(posedge clock);
		error_cnt++;
		$display("ERROR at %0t: seen %0h expected %0h", $time, 0, 1);
		conclude();
	end
endmodule : tb_serial_flash_command_decoder

`default_nettype wire
